// File: clpd_core_ctrl.sv
// Run-state, low-power and debug-halt controller with flag and address helpers
// Function
// - Wait instruction clears the interrupt mask flag.
// - Wait then gates CPU clocks until interrupt or reset.
// - Interrupt or reset in wait restarts clocks, handled normally.
// - Halt command during wait restarts clocks and enters debug mode.
// - Optional minimal clocks keep running in stop for periodic wake.
// - Debug enable set forces oscillator running during stop.
// - With oscillator held, halt command in stop enters debug mode.
// - Enter-debug instruction switches core into debug mode.
// - Debug mode left only by reset, resume, step or tagged resume.
// - Flags: V bit7, H bit4, I bit3, N bit2, Z bit1, C bit0.
// - Carry flag takes carry out of result bit 7.
// - Word operand big-endian, low byte at address plus one.
// - Direct address is zero high byte plus 8-bit low byte.
// - Branch target adds signed 8-bit offset to next address.
// - Bit instructions select bit 0 to 7 of the byte.
// - 8-bit index offset is unsigned, added to 16-bit index.
// - 16-bit offset arithmetic wraps within 16-bit space.
// - Interrupt entry pushes PC low, PC high, X, A, flags; sets mask.
`timescale 1ns/10ps
module clpd_core_ctrl (
   input logic aclk,
   input logic aresetn,
   input clpd_pkg::clpd_axi_req_t axi_req,
   output clpd_pkg::clpd_axi_rsp_t axi_rsp,
   input clpd_pkg::clpd_core_in_t core_in,
   input clpd_pkg::clpd_dbg_cmd_t dbg_cmd,
   input logic wake_async,
   input logic bdm_strap,
   output clpd_pkg::clpd_core_out_t core_out
);

   typedef struct packed {
      clpd_pkg::clpd_state_t state;
      logic [7:0] flags;
      logic dbg_en;
      logic keep_clk;
      logic boot_done;
      logic [2:0] sync;
      logic wake_lvl;
      logic [2:0] push_cnt;
      logic [15:0] snap_pc;
      logic [7:0] snap_x;
      logic [7:0] snap_a;
      logic [31:0] agen_oper;
      logic [5:0] agen_mode;
      logic [7:0] alu_res;
      logic aw_have;
      logic [7:0] aw_addr;
      logic w_have;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      clpd_pkg::clpd_axi_rsp_t rsp;
      clpd_pkg::clpd_core_out_t out;
   } clpd_regs_t;

   clpd_regs_t s;
   clpd_regs_t n;

   assign axi_rsp = s.rsp;
   assign core_out = s.out;

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      logic [7:0] alu_a;
      logic [7:0] alu_b;
      logic [8:0] sum9;
      logic [4:0] sum5;
      logic [15:0] ag_base;
      logic [15:0] ag_off;
      logic [15:0] ag_addr;
      logic [7:0] ag_mask;
      logic wake_evt;
      logic any_resume;
      logic wr_go;
      alu_a = s.w_data[7:0];
      alu_b = s.w_data[15:8];
      sum9 = {1'b0, alu_a} + {1'b0, alu_b} + {8'h00, s.w_data[clpd_pkg::ALU_CIN]};
      sum5 = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]} + {4'h0, s.w_data[clpd_pkg::ALU_CIN]};
      ag_base = s.agen_oper[15:0];
      ag_off = s.agen_oper[31:16];
      ag_addr = 16'h0000;
      ag_mask = 8'h01 << s.agen_mode[5:3];
      wake_evt = (s.sync[1] == s.sync[2]) && s.sync[2] && !s.wake_lvl;
      any_resume = dbg_cmd.resume || dbg_cmd.single_step || dbg_cmd.tagged_resume;
      wr_go = s.aw_have && s.w_have && !s.rsp.bvalid;
      n = s;
      n.out.vector_fetch = 1'b0;
      n.out.resume_pulse = 1'b0;
      n.out.step_pulse = 1'b0;
      n.out.tag_pulse = 1'b0;

      // Wake pin is asynchronous; only agreeing late stages count
      n.sync = {s.sync[1:0], wake_async};
      if (s.sync[1] == s.sync[2]) begin
         n.wake_lvl = s.sync[2];
      end

      // Address generator, all sums cut to 16 bits so they wrap
      case (clpd_pkg::clpd_agen_t'(s.agen_mode[2:0]))
         clpd_pkg::AG_DIRECT: ag_addr = {8'h00, ag_off[7:0]};
         clpd_pkg::AG_IX1: ag_addr = ag_base + {8'h00, ag_off[7:0]};
         clpd_pkg::AG_IX2: ag_addr = ag_base + ag_off;
         clpd_pkg::AG_REL: ag_addr = ag_base + {{8{ag_off[7]}}, ag_off[7:0]};
         clpd_pkg::AG_WORD_LO: ag_addr = ag_base + 16'h0001;
         default: ag_addr = ag_base;
      endcase

      ////////////////////////////////////////////////////////////////////////
      // Register bus, write path
      if (axi_req.awvalid && s.rsp.awready) begin
         n.aw_have = 1'b1;
         n.aw_addr = axi_req.awaddr;
      end
      if (axi_req.wvalid && s.rsp.wready) begin
         n.w_have = 1'b1;
         n.w_data = axi_req.wdata;
         n.w_strb = axi_req.wstrb;
      end
      if (s.rsp.bvalid && axi_req.bready) begin
         n.rsp.bvalid = 1'b0;
      end
      if (wr_go) begin
         n.aw_have = 1'b0;
         n.w_have = 1'b0;
         n.rsp.bvalid = 1'b1;
         n.rsp.bresp = clpd_pkg::RESP_OKAY;
         case (s.aw_addr)
            clpd_pkg::OFS_FLAGS: begin
               if (s.w_strb[0]) begin
                  n.flags = s.w_data[7:0];
               end
            end
            clpd_pkg::OFS_CTRL: begin
               if (s.w_strb[0]) begin
                  n.dbg_en = s.w_data[clpd_pkg::CTRL_DBG_EN];
                  n.keep_clk = s.w_data[clpd_pkg::CTRL_KEEP_CLK];
               end
            end
            clpd_pkg::OFS_AGEN_OPER: begin
               for (int i = 0; i < 4; i++) begin
                  if (s.w_strb[i]) begin
                     n.agen_oper[8*i +: 8] = s.w_data[8*i +: 8];
                  end
               end
            end
            clpd_pkg::OFS_AGEN_MODE: begin
               if (s.w_strb[0]) begin
                  n.agen_mode = s.w_data[5:0];
               end
            end
            clpd_pkg::OFS_ALU: begin
               // Operands and carry-in come in one write, so it must hold the three low lanes
               if (s.w_strb[0] && s.w_strb[1] && s.w_strb[2]) begin
                  n.alu_res = sum9[7:0];
                  n.flags[clpd_pkg::FLAG_C] = sum9[8];
                  n.flags[clpd_pkg::FLAG_H] = sum5[4];
                  n.flags[clpd_pkg::FLAG_V] = (alu_a[7] == alu_b[7]) && (sum9[7] != alu_a[7]);
                  n.flags[clpd_pkg::FLAG_N] = sum9[7];
                  n.flags[clpd_pkg::FLAG_Z] = (sum9[7:0] == 8'h00);
               end
            end
            clpd_pkg::OFS_STATUS, clpd_pkg::OFS_AGEN_RES: begin
               n.rsp.bresp = clpd_pkg::RESP_OKAY;
            end
            default: n.rsp.bresp = clpd_pkg::RESP_SLVERR;
         endcase
      end
      n.rsp.awready = !n.aw_have && !n.rsp.bvalid;
      n.rsp.wready = !n.w_have && !n.rsp.bvalid;

      ////////////////////////////////////////////////////////////////////////
      // Register bus, read path
      if (s.rsp.rvalid && axi_req.rready) begin
         n.rsp.rvalid = 1'b0;
      end
      if (axi_req.arvalid && s.rsp.arready) begin
         n.rsp.rvalid = 1'b1;
         n.rsp.rresp = clpd_pkg::RESP_OKAY;
         n.rsp.rdata = 32'h0000_0000;
         case (axi_req.araddr)
            clpd_pkg::OFS_FLAGS: n.rsp.rdata[7:0] = s.flags;
            clpd_pkg::OFS_CTRL: n.rsp.rdata[1:0] = {s.keep_clk, s.dbg_en};
            clpd_pkg::OFS_STATUS: n.rsp.rdata = {s.out.ret_pc, 13'h0000, s.state};
            clpd_pkg::OFS_AGEN_OPER: n.rsp.rdata = s.agen_oper;
            clpd_pkg::OFS_AGEN_MODE: n.rsp.rdata[5:0] = s.agen_mode;
            clpd_pkg::OFS_AGEN_RES: n.rsp.rdata[23:0] = {ag_mask, ag_addr};
            clpd_pkg::OFS_ALU: n.rsp.rdata[7:0] = s.alu_res;
            default: n.rsp.rresp = clpd_pkg::RESP_SLVERR;
         endcase
      end
      n.rsp.arready = !n.rsp.rvalid;

      ////////////////////////////////////////////////////////////////////////
      // Run-state machine; hardware flag changes follow bus writes so they win
      if (dbg_cmd.set_enable) begin
         n.dbg_en = 1'b1;
      end
      case (s.state)
         clpd_pkg::ST_RUN: begin
            if (core_in.exec_enter_debug) begin
               n.state = clpd_pkg::ST_BDM;
            end else if (core_in.exec_stop) begin
               n.state = clpd_pkg::ST_STOP;
               n.snap_pc = core_in.pc_next;
            end else if (core_in.exec_wait) begin
               n.flags[clpd_pkg::FLAG_I] = 1'b0;
               n.state = clpd_pkg::ST_WAIT;
               n.snap_pc = core_in.pc_next;
            end else if (core_in.instr_boundary && core_in.irq_pending &&
                         !s.flags[clpd_pkg::FLAG_I]) begin
               n.state = clpd_pkg::ST_IRQ;
               n.push_cnt = 3'h0;
               n.snap_pc = core_in.pc_next;
               n.snap_x = core_in.x_reg;
               n.snap_a = core_in.a_reg;
            end
         end
         clpd_pkg::ST_WAIT: begin
            if (dbg_cmd.halt) begin
               n.state = clpd_pkg::ST_BDM;
            end else if (core_in.irq_pending) begin
               n.state = clpd_pkg::ST_IRQ;
               n.push_cnt = 3'h0;
               n.snap_x = core_in.x_reg;
               n.snap_a = core_in.a_reg;
            end
         end
         clpd_pkg::ST_STOP: begin
            if (dbg_cmd.halt && s.dbg_en) begin
               n.state = clpd_pkg::ST_BDM;
            end else if (core_in.irq_pending) begin
               n.state = clpd_pkg::ST_IRQ;
               n.push_cnt = 3'h0;
               n.snap_x = core_in.x_reg;
               n.snap_a = core_in.a_reg;
            end else if (s.keep_clk && wake_evt) begin
               n.state = clpd_pkg::ST_RUN;
            end
         end
         clpd_pkg::ST_IRQ: begin
            if (s.push_cnt == clpd_pkg::PUSH_LAST) begin
               n.flags[clpd_pkg::FLAG_I] = 1'b1;
               n.out.vector_fetch = 1'b1;
               n.state = clpd_pkg::ST_RUN;
            end else begin
               n.push_cnt = s.push_cnt + 3'h1;
            end
         end
         clpd_pkg::ST_BDM: begin
            if (any_resume) begin
               n.state = clpd_pkg::ST_RUN;
               n.out.resume_pulse = dbg_cmd.resume;
               n.out.step_pulse = dbg_cmd.single_step;
               n.out.tag_pulse = dbg_cmd.tagged_resume;
            end
         end
         default: n.state = clpd_pkg::ST_RUN;
      endcase

      // Strap caught once, on the first edge after reset release
      if (!s.boot_done) begin
         n.boot_done = 1'b1;
         if (bdm_strap) begin
            n.state = clpd_pkg::ST_BDM;
            n.dbg_en = 1'b1;
         end
      end

      ////////////////////////////////////////////////////////////////////////
      // Registered outputs
      n.out.cpu_clk_en = (n.state != clpd_pkg::ST_WAIT) && (n.state != clpd_pkg::ST_STOP);
      n.out.fetch_en = (n.state == clpd_pkg::ST_RUN);
      n.out.osc_keep = (n.state == clpd_pkg::ST_STOP) && n.dbg_en;
      n.out.min_clk_keep = (n.state == clpd_pkg::ST_STOP) && n.keep_clk;
      n.out.in_debug = (n.state == clpd_pkg::ST_BDM);
      n.out.push_valid = (n.state == clpd_pkg::ST_IRQ);
      n.out.ret_pc = n.snap_pc;
      case (n.push_cnt)
         3'h0: n.out.push_data = n.snap_pc[7:0];
         3'h1: n.out.push_data = n.snap_pc[15:8];
         3'h2: n.out.push_data = n.snap_x;
         3'h3: n.out.push_data = n.snap_a;
         default: n.out.push_data = n.flags;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
         s.flags <= clpd_pkg::FLAGS_RESET;
      end else begin
         s <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   logic run_wait;
   assign run_wait = (s.state == clpd_pkg::ST_RUN) && s.boot_done && core_in.exec_wait &&
                     !core_in.exec_stop && !core_in.exec_enter_debug;

   sequence push_head_s;
      core_out.push_valid && core_out.push_data == s.snap_pc[7:0] ##1
      core_out.push_valid && core_out.push_data == s.snap_pc[15:8];
   endsequence

   sequence push_tail_s;
      core_out.push_valid && core_out.push_data == s.snap_x ##1
      core_out.push_valid && core_out.push_data == s.snap_a ##1
      core_out.push_valid && !s.flags[clpd_pkg::FLAG_I];
   endsequence

   wait_mask_clear_a: assert property (run_wait |=> !s.flags[clpd_pkg::FLAG_I])
      else $error("wait did not clear interrupt mask");
   wait_clk_gate_a: assert property (run_wait |=> !core_out.cpu_clk_en [*1] ##0
      s.state == clpd_pkg::ST_WAIT)
      else $error("wait did not gate cpu clocks");
   wait_irq_wake_a: assert property ((s.state == clpd_pkg::ST_WAIT) && core_in.irq_pending &&
      !dbg_cmd.halt |=> core_out.cpu_clk_en && core_out.push_valid)
      else $error("interrupt did not wake from wait");
   wait_halt_a: assert property ((s.state == clpd_pkg::ST_WAIT) && dbg_cmd.halt
      |=> core_out.in_debug && core_out.cpu_clk_en)
      else $error("halt in wait did not enter debug");
   stop_keep_clk_a: assert property ((s.state == clpd_pkg::ST_STOP) && s.keep_clk
      |-> core_out.min_clk_keep)
      else $error("minimal clocks not kept in stop");
   stop_osc_hold_a: assert property ((s.state == clpd_pkg::ST_STOP) && s.dbg_en
      |-> core_out.osc_keep && !core_out.cpu_clk_en)
      else $error("oscillator not held in stop");
   stop_halt_a: assert property ((s.state == clpd_pkg::ST_STOP) && s.dbg_en && dbg_cmd.halt
      |=> core_out.in_debug ##0 core_out.cpu_clk_en)
      else $error("halt in stop did not enter debug");
   enter_debug_a: assert property ((s.state == clpd_pkg::ST_RUN) && core_in.exec_enter_debug
      |=> core_out.in_debug && !core_out.fetch_en)
      else $error("enter-debug instruction ignored");
   debug_hold_a: assert property (core_out.in_debug && s.boot_done && !dbg_cmd.resume &&
      !dbg_cmd.single_step && !dbg_cmd.tagged_resume |=> core_out.in_debug)
      else $error("debug mode left without resume");
   push_order_a: assert property ($rose(core_out.push_valid) |-> push_head_s ##1 push_tail_s
      ##1 !core_out.push_valid && s.flags[clpd_pkg::FLAG_I] && core_out.vector_fetch)
      else $error("interrupt push order wrong");
   hold_ret_pc_a: assert property (run_wait |=> core_out.ret_pc == $past(core_in.pc_next) &&
      !core_out.fetch_en)
      else $error("return pc not held");

endmodule : clpd_core_ctrl

// File: clpd_dbg_host.sv
// Behavioural debug host that issues one-cycle serial command pulses
`timescale 1ns/10ps
module clpd_dbg_host (
   input logic aclk,
   output clpd_pkg::clpd_dbg_cmd_t dbg_cmd
);
   ////////////////////////////////////////////////////////////////////////////
   initial dbg_cmd = '0;

   // Kind 0 halt, 1 resume, 2 step, 3 tagged resume, 4 enable; gap models a slow host
   task automatic send(input int kind, input int gap);
      repeat (gap) @(posedge aclk);
      @(posedge aclk);
      case (kind)
         0: dbg_cmd.halt <= 1'b1;
         1: dbg_cmd.resume <= 1'b1;
         2: dbg_cmd.single_step <= 1'b1;
         3: dbg_cmd.tagged_resume <= 1'b1;
         default: dbg_cmd.set_enable <= 1'b1;
      endcase
      @(posedge aclk);
      dbg_cmd <= '0;
      #1;
   endtask : send
endmodule : clpd_dbg_host

// File: clpd_pkg.sv
// Shared constants and carrier types for the CPU run-state and debug-halt controller
package clpd_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [7:0] OFS_FLAGS = 8'h00;
   localparam logic [7:0] OFS_CTRL = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_AGEN_OPER = 8'h0C;
   localparam logic [7:0] OFS_AGEN_MODE = 8'h10;
   localparam logic [7:0] OFS_AGEN_RES = 8'h14;
   localparam logic [7:0] OFS_ALU = 8'h18;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions and reset values
   localparam int FLAG_V = 7;
   localparam int FLAG_H = 4;
   localparam int FLAG_I = 3;
   localparam int FLAG_N = 2;
   localparam int FLAG_Z = 1;
   localparam int FLAG_C = 0;
   localparam int CTRL_DBG_EN = 0;
   localparam int CTRL_KEEP_CLK = 1;
   localparam int ALU_CIN = 16;
   localparam logic [7:0] FLAGS_RESET = 8'h08;
   localparam logic [2:0] PUSH_LAST = 3'h4;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // Enumerations
   typedef enum logic [2:0] {
      ST_RUN = 3'b000,
      ST_IRQ = 3'b001,
      ST_WAIT = 3'b011,
      ST_STOP = 3'b010,
      ST_BDM = 3'b110
   } clpd_state_t;

   typedef enum logic [2:0] {
      AG_DIRECT = 3'h0,
      AG_IX1 = 3'h1,
      AG_IX2 = 3'h2,
      AG_REL = 3'h3,
      AG_WORD_LO = 3'h4
   } clpd_agen_t;

   ////////////////////////////////////////////////////////////////////////////
   // Carriers
   typedef struct packed {
      logic awvalid;
      logic [7:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [7:0] araddr;
      logic rready;
   } clpd_axi_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } clpd_axi_rsp_t;

   typedef struct packed {
      logic exec_wait;
      logic exec_stop;
      logic exec_enter_debug;
      logic instr_boundary;
      logic irq_pending;
      logic [15:0] pc_next;
      logic [7:0] x_reg;
      logic [7:0] a_reg;
   } clpd_core_in_t;

   typedef struct packed {
      logic halt;
      logic resume;
      logic single_step;
      logic tagged_resume;
      logic set_enable;
   } clpd_dbg_cmd_t;

   typedef struct packed {
      logic cpu_clk_en;
      logic fetch_en;
      logic osc_keep;
      logic min_clk_keep;
      logic in_debug;
      logic push_valid;
      logic [7:0] push_data;
      logic vector_fetch;
      logic resume_pulse;
      logic step_pulse;
      logic tag_pulse;
      logic [15:0] ret_pc;
   } clpd_core_out_t;

endpackage : clpd_pkg

// File: cpu_low_power_debug_state_test.sv
// Self-checking bench for the run-state and debug-halt controller
`timescale 1ns/10ps
module cpu_low_power_debug_state_test;
   logic aclk;
   logic aresetn;
   clpd_pkg::clpd_axi_req_t rq;
   clpd_pkg::clpd_axi_rsp_t rs;
   clpd_pkg::clpd_core_in_t ci;
   clpd_pkg::clpd_dbg_cmd_t dc;
   clpd_pkg::clpd_core_out_t co;
   logic wake;
   logic strap;
   int miscompares;
   int checked;
   logic [15:0] ag [5] = '{16'h0080, 16'h0070, 16'h1270, 16'hFF70, 16'hFFF1};
   logic [7:0] pb [5] = '{8'h34, 8'h12, 8'h56, 8'h78, 8'h81};

   ////////////////////////////////////////////////////////////////////////////
   clpd_core_ctrl u_dut (.aclk(aclk), .aresetn(aresetn), .axi_req(rq), .axi_rsp(rs),
      .core_in(ci), .dbg_cmd(dc), .wake_async(wake), .bdm_strap(strap), .core_out(co));
   clpd_dbg_host u_host (.aclk(aclk), .dbg_cmd(dc));

   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : cmp

   task automatic cmpb(input logic got, input logic exp, input string m);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t %s got %b exp %b", $time, m, got, exp);
      end
   endtask : cmpb

   // Address and data offered together; bready held until the answer
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw;
      logic w;
      aw = 1'b1;
      w = 1'b1;
      @(posedge aclk);
      rq.awvalid <= 1'b1;
      rq.awaddr <= a;
      rq.wvalid <= 1'b1;
      rq.wdata <= d;
      rq.wstrb <= 4'hF;
      rq.bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (aw && rs.awready === 1'b1) begin
            aw = 1'b0;
            rq.awvalid <= 1'b0;
         end
         if (w && rs.wready === 1'b1) begin
            w = 1'b0;
            rq.wvalid <= 1'b0;
         end
      end while (aw || w || rs.bvalid !== 1'b1);
      cmp({30'h0, rs.bresp}, {30'h0, clpd_pkg::RESP_OKAY}, "write resp");
      rq.bready <= 1'b0;
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] resp);
      logic ar;
      ar = 1'b1;
      @(posedge aclk);
      rq.arvalid <= 1'b1;
      rq.araddr <= a;
      rq.rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (ar && rs.arready === 1'b1) begin
            ar = 1'b0;
            rq.arvalid <= 1'b0;
         end
      end while (ar || rs.rvalid !== 1'b1);
      cmp(rs.rdata, exp, "read data");
      cmp({30'h0, rs.rresp}, {30'h0, resp}, "read resp");
      rq.rready <= 1'b0;
   endtask : rdc

   // Kind 0 wait, 1 stop, 2 enter debug
   task automatic pulse(input int k);
      @(posedge aclk);
      ci.exec_wait <= (k == 0);
      ci.exec_stop <= (k == 1);
      ci.exec_enter_debug <= (k == 2);
      @(posedge aclk);
      ci.exec_wait <= 1'b0;
      ci.exec_stop <= 1'b0;
      ci.exec_enter_debug <= 1'b0;
      #1;
   endtask : pulse

   // Five stacked bytes, then the vector fetch once the mask is set
   task automatic chk_push();
      for (int i = 0; i < 5; i++) begin
         cmp({24'h0, co.push_data}, {24'h0, pb[i]}, "push byte");
         @(posedge aclk);
         #1;
      end
      cmpb(co.push_valid, 1'b0, "push count");
      cmpb(co.vector_fetch, 1'b1, "vector fetch");
   endtask : chk_push

   task automatic end_sim();
      $display("Counts: %0d mismatches in %0d checks", miscompares, checked);
      if (miscompares == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_sim

   ////////////////////////////////////////////////////////////////////////////
   // Whole run is a few hundred cycles
   initial begin
      #100000;
      miscompares++;
      end_sim();
   end

   initial begin
      miscompares = 0;
      checked = 0;
      aresetn = 1'b0;
      rq = '0;
      ci = '0;
      wake = 1'b0;
      strap = 1'b0;
      ci.pc_next = 16'h1234;
      ci.x_reg = 8'h56;
      ci.a_reg = 8'h78;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      #1;
      cmpb(co.fetch_en, 1'b1, "run after reset");
      rdc(clpd_pkg::OFS_FLAGS, 32'h0000_0008, 2'h0);
      rdc(clpd_pkg::OFS_CTRL, 32'h0000_0000, 2'h0);
      rdc(8'h40, 32'h0000_0000, clpd_pkg::RESP_SLVERR);
      // Overflow, zero and carry out of bit 7; then half carry with carry-in
      wr(clpd_pkg::OFS_ALU, 32'h0000_8080);
      rdc(clpd_pkg::OFS_ALU, 32'h0000_0000, 2'h0);
      rdc(clpd_pkg::OFS_FLAGS, 32'h0000_008B, 2'h0);
      wr(clpd_pkg::OFS_ALU, 32'h0001_010F);
      rdc(clpd_pkg::OFS_ALU, 32'h0000_0011, 2'h0);
      rdc(clpd_pkg::OFS_FLAGS, 32'h0000_0018, 2'h0);
      // Base near the top so the indexed and relative modes show wrap or sign
      wr(clpd_pkg::OFS_AGEN_OPER, 32'h1280_FFF0);
      for (int m = 0; m < 8; m++) begin
         wr(clpd_pkg::OFS_AGEN_MODE, 32'(m * 8 + (m < 5 ? m : 4)));
         rdc(clpd_pkg::OFS_AGEN_RES, {8'h00, 8'h01 << m, ag[m < 5 ? m : 4]}, 2'h0);
      end
      // Wait, then interrupt wake with stacking
      wr(clpd_pkg::OFS_FLAGS, 32'h0000_0089);
      pulse(0);
      cmpb(co.cpu_clk_en, 1'b0, "wait gates clock");
      cmpb(co.fetch_en, 1'b0, "wait no fetch");
      cmp({16'h0, co.ret_pc}, 32'h0000_1234, "return pc");
      rdc(clpd_pkg::OFS_FLAGS, 32'h0000_0081, 2'h0);
      rdc(clpd_pkg::OFS_STATUS, 32'h1234_0003, 2'h0);
      cmpb(co.cpu_clk_en, 1'b0, "wait holds");
      @(posedge aclk);
      ci.irq_pending <= 1'b1;
      for (int n = 0; n < 20 && co.push_valid !== 1'b1; n++) begin
         @(posedge aclk);
         #1;
      end
      cmpb(co.cpu_clk_en, 1'b1, "irq restarts clock");
      chk_push();
      @(posedge aclk);
      ci.irq_pending <= 1'b0;
      rdc(clpd_pkg::OFS_FLAGS, 32'h0000_0089, 2'h0);
      // Halt command while waiting
      pulse(0);
      u_host.send(0, 2);
      cmpb(co.in_debug, 1'b1, "halt in wait");
      cmpb(co.cpu_clk_en, 1'b1, "halt clocks");
      u_host.send(1, 0);
      // Each way out of debug, slow host, halt ignored meanwhile
      for (int k = 1; k < 4; k++) begin
         pulse(2);
         cmpb(co.fetch_en, 1'b0, "debug no fetch");
         u_host.send(0, k);
         cmpb(co.in_debug, 1'b1, "debug stays");
         u_host.send(k, k * 3);
         cmp({29'h0, co.resume_pulse, co.step_pulse, co.tag_pulse}, 32'(4 >> (k - 1)), "exit kind");
         cmpb(co.in_debug, 1'b0, "debug left");
      end
      // Stop with serial enable and keep option
      wr(clpd_pkg::OFS_CTRL, 32'h0000_0002);
      u_host.send(4, 0);
      rdc(clpd_pkg::OFS_CTRL, 32'h0000_0003, 2'h0);
      pulse(1);
      cmpb(co.osc_keep, 1'b1, "osc held");
      cmpb(co.min_clk_keep, 1'b1, "min clocks");
      cmpb(co.cpu_clk_en, 1'b0, "stop gates");
      u_host.send(0, 4);
      cmpb(co.in_debug, 1'b1, "halt in stop");
      cmpb(co.cpu_clk_en, 1'b1, "stop halt clocks");
      u_host.send(1, 0);
      // Without enable the halt is refused; periodic wake returns to run
      wr(clpd_pkg::OFS_CTRL, 32'h0000_0002);
      pulse(1);
      cmpb(co.osc_keep, 1'b0, "osc free");
      u_host.send(0, 0);
      cmpb(co.in_debug, 1'b0, "halt refused");
      cmpb(co.cpu_clk_en, 1'b0, "still stopped");
      @(posedge aclk);
      wake <= 1'b1;
      for (int n = 0; n < 10 && co.fetch_en !== 1'b1; n++) begin
         @(posedge aclk);
         #1;
      end
      cmpb(co.fetch_en, 1'b1, "periodic wake");
      @(posedge aclk);
      wake <= 1'b0;
      // Interrupt at a boundary while running, then again with the mask set
      for (int j = 0; j < 2; j++) begin
         @(posedge aclk);
         ci.irq_pending <= 1'b1;
         ci.instr_boundary <= 1'b1;
         @(posedge aclk);
         ci.instr_boundary <= 1'b0;
         #1;
         cmpb(co.push_valid, j == 0, "irq at boundary");
         if (j == 0) begin
            chk_push();
         end
      end
      // Reset with strap comes up in debug with enable set; plain reset leaves debug
      for (int r = 1; r >= 0; r--) begin
         @(posedge aclk);
         ci.irq_pending <= 1'b0;
         aresetn <= 1'b0;
         strap <= (r == 1);
         repeat (2) @(posedge aclk);
         aresetn <= 1'b1;
         repeat (2) @(posedge aclk);
         #1;
         cmpb(co.in_debug, r == 1, "reset strap");
         rdc(clpd_pkg::OFS_CTRL, 32'(r), 2'h0);
      end
      end_sim();
   end
endmodule : cpu_low_power_debug_state_test
